// File: bus_sizing_seq.sv
`timescale 1ns/1ps
`default_nettype none

module bus_sizing_seq (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // operand request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire dbs_pkg::xfer_req_s REQ,
  // operand answer
  output logic RESP_VALID,
  input wire logic RESP_READY,
  output dbs_pkg::xfer_resp_s RESP,
  // address and size
  output logic [dbs_pkg::ADDR_W-1:1] BUS_ADDR,
  output logic BYTE_OFFSET_BIT,
  output logic REMAINING_SIZE_HI,
  output logic REMAINING_SIZE_LO,
  output logic BUS_RW,
  output logic ADDR_STROBE_N,
  output logic DATA_STROBE_N,
  // data lines
  input wire logic [dbs_pkg::DATA_W-1:0] DATA_IN,
  output logic [dbs_pkg::DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  // termination
  input wire logic PORT_ACK_WIDE_N,
  input wire logic PORT_ACK_NARROW_N,
  input wire logic BUS_FAULT_IN_N
);

  dbs_pkg::seq_state_e state_r, state_nxt;
  logic [2:0] rem_r;
  logic [dbs_pkg::ADDR_W-1:0] addr_r;
  logic [dbs_pkg::OPER_W-1:0] wsh_r;
  logic [dbs_pkg::OPER_W-1:0] rd_r;
  logic [dbs_pkg::DATA_W-1:0] dout_r;
  logic write_r;
  logic fault_r;
  logic misal_r;

  // request decode
  wire req_take = REQ_VALID & (state_r == dbs_pkg::ST_IDLE);
  wire req_misal = (REQ.size != dbs_pkg::OP_BYTE) & REQ.addr[0];
  wire [2:0] req_cnt = (REQ.size == dbs_pkg::OP_LONG) ? dbs_pkg::CNT_LONG :
                       (REQ.size == dbs_pkg::OP_WORD) ? dbs_pkg::CNT_WORD :
                       dbs_pkg::CNT_BYTE;
  // operand left-justified so byte 0 always sits at the top
  wire [dbs_pkg::OPER_W-1:0] req_wsh =
    (REQ.size == dbs_pkg::OP_LONG) ? REQ.wdata :
    (REQ.size == dbs_pkg::OP_WORD) ? {REQ.wdata[15:0], 16'h0000} :
    {REQ.wdata[7:0], 24'h000000};

  // termination decode, sampled only while strobing
  wire in_strobe = (state_r == dbs_pkg::ST_STROBE);
  wire [1:0] ack_code = {PORT_ACK_WIDE_N, PORT_ACK_NARROW_N};
  // reserved code is treated as a failed access rather than hanging
  wire fault_seen = in_strobe &
    (~BUS_FAULT_IN_N | (ack_code == dbs_pkg::ACK_RSVD));
  wire ack16 = in_strobe & BUS_FAULT_IN_N &
    (ack_code == dbs_pkg::ACK_PORT16);
  wire ack8 = in_strobe & BUS_FAULT_IN_N &
    (ack_code == dbs_pkg::ACK_PORT8);
  wire cycle_end = ack16 | ack8 | fault_seen;

  // lane routing and acceptance
  wire odd = addr_r[0];
  wire two_lane = ~odd & (rem_r >= dbs_pkg::CNT_WORD);
  wire [2:0] take_n = (ack16 & two_lane) ? dbs_pkg::CNT_WORD :
                      dbs_pkg::CNT_BYTE;
  wire [2:0] rem_after = 3'(rem_r - take_n);
  wire [7:0] op_b0 = wsh_r[31:24];
  wire [7:0] op_b1 = wsh_r[23:16];
  // unused lane carries a copy so all sixteen lines stay driven
  wire [dbs_pkg::DATA_W-1:0] lanes = two_lane ? {op_b0, op_b1} :
                                     {op_b0, op_b0};
  wire [7:0] rd_byte = (ack16 & odd) ? DATA_IN[7:0] :
                       DATA_IN[15:8];

  // outputs
  assign REQ_READY = (state_r == dbs_pkg::ST_IDLE);
  assign BUS_ADDR = addr_r[dbs_pkg::ADDR_W-1:1];
  assign BYTE_OFFSET_BIT = addr_r[0];
  // count 4,3,2,1 maps straight onto codes 00,11,10,01
  assign {REMAINING_SIZE_HI, REMAINING_SIZE_LO} = rem_r[1:0];
  assign BUS_RW = ~write_r;
  assign ADDR_STROBE_N = ~in_strobe;
  assign DATA_STROBE_N = ~in_strobe;
  assign DATA_OUT = dout_r;
  assign DATA_OE = write_r & in_strobe;

  wire resp_ready;
  wire resp_push = (state_r == dbs_pkg::ST_RESP);
  dbs_pkg::xfer_resp_s resp_word;
  assign resp_word = '{rdata: rd_r, fault: fault_r, misaligned: misal_r};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dbs_pkg::ST_IDLE: begin
        if (REQ_VALID) begin
          state_nxt = req_misal ? dbs_pkg::ST_RESP :
                      dbs_pkg::ST_SETUP;
        end
      end
      dbs_pkg::ST_SETUP: begin
        state_nxt = dbs_pkg::ST_STROBE;
      end
      dbs_pkg::ST_STROBE: begin
        if (fault_seen) begin
          state_nxt = dbs_pkg::ST_RESP;
        end else if (cycle_end) begin
          state_nxt = (rem_after == 3'h0) ? dbs_pkg::ST_RESP :
                      dbs_pkg::ST_SETUP;
        end
      end
      dbs_pkg::ST_RESP: begin
        if (resp_ready) state_nxt = dbs_pkg::ST_IDLE;
      end
      default: state_nxt = dbs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= dbs_pkg::ST_IDLE;
      rem_r <= dbs_pkg::REM_RST;
      addr_r <= dbs_pkg::ADDR_RST;
      wsh_r <= dbs_pkg::OPER_RST;
      rd_r <= dbs_pkg::OPER_RST;
      dout_r <= dbs_pkg::DOUT_RST;
      write_r <= 1'b0;
      fault_r <= 1'b0;
      misal_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (req_take) begin
        rem_r <= req_cnt;
        addr_r <= REQ.addr;
        wsh_r <= req_wsh;
        rd_r <= dbs_pkg::OPER_RST;
        write_r <= REQ.write;
        fault_r <= 1'b0;
        misal_r <= req_misal;
      end
      if (state_r == dbs_pkg::ST_SETUP) dout_r <= lanes;
      if (fault_seen) fault_r <= 1'b1;
      if (ack16 | ack8) begin
        rem_r <= rem_after;
        addr_r <= dbs_pkg::ADDR_W'(addr_r + {21'h0, take_n});
        wsh_r <= (take_n == dbs_pkg::CNT_WORD) ? {wsh_r[15:0], 16'h0000} :
                 {wsh_r[23:0], 8'h00};
        rd_r <= (take_n == dbs_pkg::CNT_WORD) ? {rd_r[15:0], DATA_IN} :
                {rd_r[23:0], rd_byte};
      end
    end
  end

  // answers queue here so a stalled consumer only holds the sequencer
  resp_buf2 #(
    .WIDTH($bits(dbs_pkg::xfer_resp_s))
  ) u_resp_buf (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .in_valid(resp_push),
    .in_ready(resp_ready),
    .in_data(resp_word),
    .out_valid(RESP_VALID),
    .out_ready(RESP_READY),
    .out_data(RESP)
  );

  wire [1:0] size_pins = {REMAINING_SIZE_HI, REMAINING_SIZE_LO};

  property p_long_start;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (req_take && REQ.size == dbs_pkg::OP_LONG && !req_misal)
      |=> (size_pins == dbs_pkg::SZ_LONG && !BYTE_OFFSET_BIT)
          ##1 !ADDR_STROBE_N;
  endproperty
  a_long_start: assert property (p_long_start)
    else $error("long operand did not start with size code four");

  property p_three_odd;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (!ADDR_STROBE_N && size_pins == dbs_pkg::SZ_THREE) |-> BYTE_OFFSET_BIT;
  endproperty
  a_three_odd: assert property (p_three_odd)
    else $error("three-byte size seen outside a long word split");

  property p_misal;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (req_take && req_misal)
      |=> (state_r == dbs_pkg::ST_RESP && ADDR_STROBE_N && misal_r);
  endproperty
  a_misal: assert property (p_misal)
    else $error("misaligned operand ran a bus cycle");

  property p_wide_two;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (ack16 && two_lane)
      |=> (rem_r == 3'($past(rem_r) - 3'h2)
           && addr_r == dbs_pkg::ADDR_W'($past(addr_r) + 24'h2));
  endproperty
  a_wide_two: assert property (p_wide_two)
    else $error("16-bit acknowledge did not retire two bytes");

  property p_narrow_one;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    ack8 |=> (rem_r == 3'($past(rem_r) - 3'h1)
              && addr_r == dbs_pkg::ADDR_W'($past(addr_r) + 24'h1));
  endproperty
  a_narrow_one: assert property (p_narrow_one)
    else $error("8-bit acknowledge did not retire one byte");

  property p_wait;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (in_strobe && BUS_FAULT_IN_N && ack_code == dbs_pkg::ACK_WAIT)
      |=> (in_strobe && $stable(rem_r) && $stable(addr_r));
  endproperty
  a_wait: assert property (p_wait)
    else $error("cycle ended without an acknowledge");

  property p_rd_low;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (ack16 && odd && !write_r) |=> rd_r[7:0] == $past(DATA_IN[7:0]);
  endproperty
  a_rd_low: assert property (p_rd_low)
    else $error("odd byte from 16-bit port not taken from lower lane");

  property p_rd_high;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (ack8 && !write_r) |=> rd_r[7:0] == $past(DATA_IN[15:8]);
  endproperty
  a_rd_high: assert property (p_rd_high)
    else $error("byte from 8-bit port not taken from upper lane");

  property p_wr_drive;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_r == dbs_pkg::ST_SETUP && write_r)
      |=> (DATA_OE && DATA_OUT[15:8] == $past(op_b0));
  endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("write cycle did not drive byte zero on upper lane");

  property p_fault;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    fault_seen |=> (state_r == dbs_pkg::ST_RESP && fault_r);
  endproperty
  a_fault: assert property (p_fault)
    else $error("bus fault did not end the transfer");

  property p_cov_long8;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (ack8 && rem_r == dbs_pkg::CNT_LONG) ##[2:20] (ack8 && rem_r == 3'h1);
  endproperty
  c_long8: cover property (p_cov_long8);

  property p_cov_long16;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (ack16 && rem_r == dbs_pkg::CNT_LONG) ##[2:20] (ack16 && rem_r == 3'h2);
  endproperty
  c_long16: cover property (p_cov_long16);

  property p_cov_stall;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (resp_push && !resp_ready);
  endproperty
  c_stall: cover property (p_cov_stall);

endmodule

`default_nettype wire

// File: bus_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
  // bus side
  input wire logic clk,
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic rw,
  input wire logic [4:0] a,
  input wire logic [1:0] size,
  input wire logic [15:0] wd,
  output logic [15:0] rd,
  output logic ack_w_n,
  output logic ack_n_n,
  output logic flt_n,
  // behaviour
  input wire logic wide,
  input wire logic [1:0] waits,
  input wire logic flt,
  input wire logic rsvd
);
  logic [7:0] mem [0:31];
  logic [1:0] cnt_r;
  logic [15:0] last_r = 16'h0000;
  logic hit;
  logic [4:0] ev;
  assign ev = {a[4:1], 1'b0};
  assign hit = !as_n && !ds_n && cnt_r == waits;
  assign ack_w_n = !(hit && !flt && (wide || rsvd));
  assign ack_n_n = !(hit && !flt && (!wide || rsvd));
  assign flt_n = !(hit && flt);
  // released lines move every cycle so a stale lane cannot match
  assign rd = !(hit && rw) ? ~last_r :
    wide ? {mem[ev], mem[ev + 5'h01]} : {mem[a], ~mem[a]};
  initial for (int i = 0; i < 32; i++) mem[i] = 8'h40 + 8'(i);
  always @(posedge clk) begin
    last_r <= rd;
    cnt_r <= as_n ? 2'h0 : cnt_r + 2'(cnt_r != waits);
    if (hit && !rw && !flt && !rsvd) begin
      if (!wide || (size == 2'h1 && !a[0])) mem[a] <= wd[15:8];
      else if (size == 2'h1) mem[a] <= wd[7:0];
      else {mem[ev], mem[ev + 5'h01]} <= wd;
    end
  end
endmodule

`default_nettype wire

// File: dbs_pkg.sv
package dbs_pkg;

  // external bus geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPER_W = 32;
  localparam int BYTE_W = 8;

  // remaining-size codes, {hi, lo}
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_THREE = 2'h3;
  localparam logic [1:0] SZ_LONG = 2'h0;

  // acknowledge pin levels, {wide_n, narrow_n}
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_RSVD = 2'h0;

  // operand byte counts
  localparam logic [2:0] CNT_BYTE = 3'h1;
  localparam logic [2:0] CNT_WORD = 3'h2;
  localparam logic [2:0] CNT_LONG = 3'h4;

  // reset values
  localparam logic [2:0] REM_RST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [OPER_W-1:0] OPER_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] DOUT_RST = 16'h0000;

  // requested operand size, same code as the size pins
  typedef enum logic [1:0] {
    OP_BYTE = 2'h1,
    OP_WORD = 2'h2,
    OP_LONG = 2'h0
  } op_size_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_RESP = 4'b1000
  } seq_state_e;

  typedef struct packed {
    logic write;
    op_size_e size;
    logic [ADDR_W-1:0] addr;
    logic [OPER_W-1:0] wdata;
  } xfer_req_s;

  typedef struct packed {
    logic [OPER_W-1:0] rdata;
    logic fault;
    logic misaligned;
  } xfer_resp_s;

endpackage

// File: resp_buf2.sv
`timescale 1ns/1ps
`default_nettype none

module resp_buf2 #(
  parameter int WIDTH = 34
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  generate
    if (WIDTH < 1) begin : g_bad
      $error("resp_buf2 needs WIDTH of at least one");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_r[g] <= '0;
        end else if (push && wp_r == 1'(g)) begin
          mem_r[g] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule

`default_nettype wire

// File: test_bus_sizing_seq.sv
`timescale 1ns/1ps
`default_nettype none

module test_bus_sizing_seq;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic resp_ready = 1'b1;
  dbs_pkg::xfer_req_s req = '0;
  dbs_pkg::xfer_resp_s resp, r;
  logic [23:1] bus_addr;
  logic offset, sz_hi, sz_lo, rw, as_n, ds_n, oe, req_ready, resp_valid;
  logic [15:0] din, dout;
  logic ack_w_n, ack_n_n, flt_n;
  logic wide = 1'b1;
  logic [1:0] waits = 2'h0;
  logic flt = 1'b0;
  logic rsvd = 1'b0;
  logic [41:0] log_q [$];
  int errors = 0;
  int n_compared = 0;

  bus_sizing_seq bus_sizing_seq_i (
    .SYS_CLK(clk), .SYS_RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ(req), .RESP_VALID(resp_valid),
    .RESP_READY(resp_ready), .RESP(resp), .BUS_ADDR(bus_addr),
    .BYTE_OFFSET_BIT(offset), .REMAINING_SIZE_HI(sz_hi),
    .REMAINING_SIZE_LO(sz_lo), .BUS_RW(rw), .ADDR_STROBE_N(as_n),
    .DATA_STROBE_N(ds_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
    .PORT_ACK_WIDE_N(ack_w_n), .PORT_ACK_NARROW_N(ack_n_n),
    .BUS_FAULT_IN_N(flt_n)
  );

  bus_slave_model bus_slave_model_i (
    .clk(clk), .as_n(as_n), .ds_n(ds_n), .rw(rw),
    .a({bus_addr[4:1], offset}), .size({sz_hi, sz_lo}), .wd(dout),
    .rd(din), .ack_w_n(ack_w_n), .ack_n_n(ack_n_n), .flt_n(flt_n),
    .wide(wide), .waits(waits), .flt(flt), .rsvd(rsvd)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // every terminated bus cycle: size, address, write lanes
  always @(posedge clk) begin
    if (!as_n && !(ack_w_n && ack_n_n && flt_n)) begin
      log_q.push_back({sz_hi, sz_lo, bus_addr, offset, dout});
      chk(oe, !rw);
    end
  end

  // scenarios pass one for a read; the request field means write
  task automatic send(input logic rd_op, input dbs_pkg::op_size_e s,
      input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{~rd_op, s, a, d};
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 100);
    req_valid <= 1'b0;
  endtask

  task automatic recv(output dbs_pkg::xfer_resp_s o);
    int n;
    n = 0;
    do @(posedge clk);
    while (!(resp_valid === 1'b1 && resp_ready) && ++n < 200);
    o = resp;
  endtask

  task automatic op(input logic w, input dbs_pkg::op_size_e s,
      input logic [23:0] a, input logic [31:0] d, input logic p16);
    log_q.delete();
    wide <= p16;
    send(w, s, a, d);
    recv(r);
  endtask

  task automatic t_long16;
    op(1'b1, dbs_pkg::OP_LONG, 24'h000010, 32'h00000000, 1'b1);
    chk(r.rdata, 32'h50515253);
    chk(log_q.size(), 2);
    chk(log_q[0][41:16], {dbs_pkg::SZ_LONG, 24'h000010});
    chk(log_q[1][41:16], {dbs_pkg::SZ_WORD, 24'h000012});
  endtask

  task automatic t_long8;
    logic [1:0] sz [4] = '{dbs_pkg::SZ_LONG, dbs_pkg::SZ_THREE,
      dbs_pkg::SZ_WORD, dbs_pkg::SZ_BYTE};
    waits <= 2'h2;
    op(1'b1, dbs_pkg::OP_LONG, 24'h000014, 32'h00000000, 1'b0);
    waits <= 2'h0;
    chk(r.rdata, 32'h54555657);
    chk(log_q.size(), 4);
    for (int i = 0; i < 4; i++)
      chk(log_q[i][41:16], {sz[i], 24'h000014 + 24'(i)});
  endtask

  task automatic t_word8;
    op(1'b0, dbs_pkg::OP_WORD, 24'h000004, 32'h0000BEEF, 1'b0);
    chk(log_q.size(), 2);
    chk(log_q[0][41:8], {dbs_pkg::SZ_WORD, 24'h000004, 8'hBE});
    chk(log_q[1][41:8], {dbs_pkg::SZ_BYTE, 24'h000005, 8'hEF});
    op(1'b1, dbs_pkg::OP_WORD, 24'h000004, 32'h00000000, 1'b1);
    chk(r.rdata, 32'h0000BEEF);
    chk(log_q.size(), 1);
  endtask

  task automatic t_bytes;
    logic [7:0] b;
    for (int i = 0; i < 2; i++) begin
      b = 8'hC0 + 8'(i);
      op(1'b0, dbs_pkg::OP_BYTE, 24'h000008 + 24'(i), {24'h000000, b}, 1'b1);
      chk(log_q[0][16:0], {i[0], b, b});
      op(1'b1, dbs_pkg::OP_BYTE, 24'h000008 + 24'(i), 32'h00000000, 1'b1);
      chk(r.rdata, {24'h000000, b});
      op(1'b1, dbs_pkg::OP_BYTE, 24'h000008 + 24'(i), 32'h00000000, 1'b0);
      chk(r.rdata, {24'h000000, b});
    end
  endtask

  task automatic t_refuse;
    op(1'b1, dbs_pkg::OP_WORD, 24'h000003, 32'h00000000, 1'b1);
    chk({r.misaligned, r.fault, log_q.size()}, {2'h2, 32'h0});
    op(1'b0, dbs_pkg::OP_LONG, 24'h000011, 32'h01234567, 1'b1);
    chk({r.misaligned, r.fault, log_q.size()}, {2'h2, 32'h0});
    for (int i = 0; i < 2; i++) begin
      flt <= !i[0];
      rsvd <= i[0];
      op(1'b1, dbs_pkg::OP_LONG, 24'h000010, 32'h00000000, 1'b1);
      chk({r.misaligned, r.fault, log_q.size()}, {2'h1, 32'h1});
    end
    flt <= 1'b0;
    rsvd <= 1'b0;
  endtask

  task automatic t_buffer;
    dbs_pkg::xfer_resp_s o;
    resp_ready <= 1'b0;
    wide <= 1'b1;
    for (int i = 0; i < 3; i++)
      send(1'b1, dbs_pkg::OP_BYTE, 24'h000018 + 24'(i), 32'h00000000);
    repeat (10) @(posedge clk);
    chk({req_ready, resp_valid}, 2'h1);
    resp_ready <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      recv(o);
      chk(o.rdata, 32'h00000058 + 32'(i));
    end
  endtask

  initial forever #12.5 clk = ~clk;

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_long16();
    t_long8();
    t_word8();
    t_bytes();
    t_refuse();
    t_buffer();
    repeat (5) @(posedge clk);
    end_of_test();
  end

  // whole run needs a few hundred cycles; this is twenty thousand
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
